// ===== include/dio_pkg.sv
// Package with the register map, field layout and timing of the digital I/O process image.
package dio_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PARAM = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IN = 8'h0c;
  localparam logic [7:0] ADDR_OUT = 8'h10;
  localparam logic [7:0] ADDR_DIAG = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
  localparam int CTRL_FAST_BIT = 0;
  localparam int CTRL_NAME_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int PARAM_CODE_LSB = 0;
  localparam int PARAM_SLOT_LSB = 4;
  localparam int PARAM_PAT_LSB = 16;
  localparam logic [3:0] PARAM_SLOT = 4'h2;
  localparam logic [15:0] PATTERN_RESET = 16'h0000;
  localparam int ST_SUP_SHORT = 0;
  localparam int ST_OUT_OVL = 1;
  localparam int ST_OUT_SHORT = 2;
  localparam int ST_ACT_UNDER = 3;
  localparam int ST_ACT_OVL = 4;
  localparam int ST_ELEC_UNDER = 5;
  localparam int DIAG_N = 7;
  localparam int GROUP_W = 4;
  localparam int IRQ_N = 4;
  localparam int IRQ_INCOMING = 0;
  localparam int IRQ_OUTGOING = 1;
  localparam int IRQ_FAILSAFE = 2;
  localparam int IRQ_READY = 3;
  localparam logic [3:0] IM_SLOT = 4'h0;
  localparam logic [2:0] IM_LAST = 3'h4;
  localparam int CNT_W = 27;
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned FAST_TIME_MS = 500;
  localparam int unsigned BOOT_TIME_MS = 1000;
  // Fast startup must finish in strictly less than the printed time.
  localparam logic [CNT_W-1:0] FAST_CYCLES = CNT_W'(FAST_TIME_MS * CLK_KHZ - 1);
  localparam logic [CNT_W-1:0] BOOT_CYCLES = CNT_W'(BOOT_TIME_MS * CLK_KHZ - 1);
  typedef enum logic [1:0] {
    FS_CLEAR = 2'b00,
    FS_SET = 2'b01,
    FS_HOLD = 2'b10,
    FS_PATTERN = 2'b11
  } fs_code_t;
  typedef enum logic {
    ST_BOOT = 1'b0,
    ST_READY = 1'b1
  } boot_state_t;
endpackage

// ===== rtl/digital_io_process_image.sv
// Process image, failsafe, diagnostics and APB register file of the digital I/O device.
`timescale 1ns/1ns
//
// Behaviour
// - Status module gives four status bytes
// - Status word bit layout, upper bits zero
// - Input n lands in byte 0 bit n
// - Output n driven by byte 0 bit n
// - Failsafe parameters accepted only for slot 2
// - Code picks clear, set, hold or pattern
// - Pattern applies only under code three
// - New diagnostic entry raises incoming alarm
// - Cleared entry raises outgoing alarm
// - Station fault lit while entries stored
// - Seven diagnostic conditions are monitored
// - Output shorts reported per four channels
// - Fast startup ready under 500 ms
// - Only first controller may write outputs
// - Records zero to four readable via slot 0
// - Replacement accepted only in default state
module digital_io_process_image #(
  parameter logic [dio_pkg::CNT_W-1:0] fast_cycles = dio_pkg::FAST_CYCLES,
  parameter logic [dio_pkg::CNT_W-1:0] boot_cycles = dio_pkg::BOOT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [7:0] device_input,
  output logic [7:0] device_output,
  output logic [7:0] in_image,
  output logic [31:0] status_word,
  input wire logic elec_undervolt,
  input wire logic actuator_supply_overload,
  input wire logic actuator_supply_undervolt,
  input wire logic actuator_supply_surge,
  input wire logic sensor_supply_surge,
  input wire logic sensor_supply_overload,
  input wire logic sensor_supply_short,
  input wire logic overtemp,
  input wire logic [7:0] out_short,
  input wire logic [7:0] out_overload,
  input wire logic conn_owner,
  input wire logic conn_shared,
  input wire logic cyc_wr,
  input wire logic cyc_src,
  input wire logic [7:0] cyc_data,
  output logic [dio_pkg::DIAG_N-1:0] alarm_incoming,
  output logic [dio_pkg::DIAG_N-1:0] alarm_outgoing,
  output logic station_fault_indicator,
  output logic ready,
  input wire logic im_req,
  input wire logic [3:0] im_slot,
  input wire logic [2:0] im_index,
  output logic im_ack,
  output logic im_nak,
  input wire logic replace_req,
  output logic replace_ack,
  output logic replace_nak
);
  import dio_pkg::*;

  function automatic logic group_fault(input logic [7:0] v, input int g);
    group_fault = |v[g*GROUP_W +: GROUP_W];
  endfunction

  logic [1:0] ctrl;
  logic [1:0] next_ctrl;
  fs_code_t fs_code;
  fs_code_t next_fs_code;
  logic [15:0] pattern;
  logic [15:0] next_pattern;
  logic [IRQ_N-1:0] irq_stat;
  logic [IRQ_N-1:0] next_irq_stat;
  logic [IRQ_N-1:0] irq_mask;
  logic [IRQ_N-1:0] next_irq_mask;
  logic [31:0] next_prdata;
  logic [7:0] out_data;
  logic [7:0] next_out_data;
  logic [7:0] next_device_output;
  logic [7:0] next_in_image;
  logic [31:0] next_status_word;
  logic [DIAG_N-1:0] diag;
  logic [DIAG_N-1:0] next_diag;
  logic [DIAG_N-1:0] diag_cond;
  logic [DIAG_N-1:0] next_alarm_in;
  logic [DIAG_N-1:0] next_alarm_out;
  boot_state_t boot;
  boot_state_t next_boot;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic failsafe;
  logic failsafe_q;
  logic owner_wr;
  logic next_im_ack;
  logic next_im_nak;
  logic next_rep_ack;
  logic next_rep_nak;
  logic [IRQ_N-1:0] events;
  logic wr_en;
  logic addr_ok;

  assign wr_en = psel & penable & pwrite;
  assign pready = penable;
  assign pslverr = psel & penable & ~addr_ok;
  assign irq = |(irq_stat & irq_mask);
  assign failsafe = (boot != ST_READY) | ~conn_owner;
  assign owner_wr = cyc_wr & ~cyc_src & conn_owner;

  always_comb
  begin
    addr_ok = 1'b1;
    unique case (paddr)
      ADDR_CTRL, ADDR_PARAM, ADDR_STATUS, ADDR_IN: addr_ok = 1'b1;
      ADDR_OUT, ADDR_DIAG, ADDR_IRQ_STAT, ADDR_IRQ_MASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Process group: image, failsafe, diagnostics, startup and side requests.
  always_comb
  begin
    diag_cond = {group_fault(out_short, 1), group_fault(out_short, 0),
                 actuator_supply_undervolt, actuator_supply_surge,
                 sensor_supply_overload, sensor_supply_surge, overtemp};
    next_diag = diag_cond;
    next_alarm_in = diag_cond & ~diag;
    next_alarm_out = ~diag_cond & diag;
    next_in_image = device_input;
    next_status_word = 32'h0;
    next_status_word[ST_SUP_SHORT] = sensor_supply_short;
    next_status_word[ST_OUT_OVL] = |out_overload;
    next_status_word[ST_OUT_SHORT] = |out_short;
    next_status_word[ST_ACT_UNDER] = actuator_supply_undervolt;
    next_status_word[ST_ACT_OVL] = actuator_supply_overload;
    next_status_word[ST_ELEC_UNDER] = elec_undervolt;
    next_out_data = owner_wr ? cyc_data : out_data;
    next_device_output = next_out_data;
    if (failsafe)
    begin
      unique case (fs_code)
        FS_CLEAR: next_device_output = 8'h00;
        FS_SET: next_device_output = 8'hff;
        FS_HOLD: next_device_output = device_output;
        FS_PATTERN: next_device_output = pattern[7:0];
      endcase
    end
    next_cnt = cnt;
    next_boot = boot;
    unique case (boot)
      ST_BOOT:
      begin
        next_cnt = cnt + 1'b1;
        if (cnt >= (ctrl[CTRL_FAST_BIT] ? fast_cycles : boot_cycles))
        begin
          next_boot = ST_READY;
        end
      end
      ST_READY: next_cnt = cnt;
    endcase
    next_im_ack = im_req & (im_slot == IM_SLOT) & (im_index <= IM_LAST);
    next_im_nak = im_req & ~next_im_ack;
    next_rep_ack = replace_req & ~ctrl[CTRL_NAME_BIT];
    next_rep_nak = replace_req & ctrl[CTRL_NAME_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_data <= 8'h00;
      device_output <= 8'h00;
      in_image <= 8'h00;
      status_word <= 32'h0;
      diag <= '0;
      alarm_incoming <= '0;
      alarm_outgoing <= '0;
      station_fault_indicator <= 1'b0;
      boot <= ST_BOOT;
      cnt <= '0;
      ready <= 1'b0;
      failsafe_q <= 1'b1;
      im_ack <= 1'b0;
      im_nak <= 1'b0;
      replace_ack <= 1'b0;
      replace_nak <= 1'b0;
    end
    else
    begin
      out_data <= next_out_data;
      device_output <= next_device_output;
      in_image <= next_in_image;
      status_word <= next_status_word;
      diag <= next_diag;
      alarm_incoming <= next_alarm_in;
      alarm_outgoing <= next_alarm_out;
      station_fault_indicator <= |next_diag;
      boot <= next_boot;
      cnt <= next_cnt;
      ready <= (next_boot == ST_READY);
      failsafe_q <= failsafe;
      im_ack <= next_im_ack;
      im_nak <= next_im_nak;
      replace_ack <= next_rep_ack;
      replace_nak <= next_rep_nak;
    end
  end

  // Bus group: registers and interrupt bookkeeping.
  always_comb
  begin
    events = '0;
    events[IRQ_INCOMING] = |next_alarm_in;
    events[IRQ_OUTGOING] = |next_alarm_out;
    events[IRQ_FAILSAFE] = failsafe & ~failsafe_q;
    events[IRQ_READY] = (next_boot == ST_READY) & (boot == ST_BOOT);
    next_ctrl = ctrl;
    next_fs_code = fs_code;
    next_pattern = pattern;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (wr_en)
    begin
      unique case (paddr)
        ADDR_CTRL: next_ctrl = pwdata[1:0];
        ADDR_PARAM:
        begin
          if (pwdata[PARAM_SLOT_LSB +: 4] == PARAM_SLOT)
          begin
            next_fs_code = fs_code_t'(pwdata[PARAM_CODE_LSB +: 2]);
            next_pattern = pwdata[PARAM_PAT_LSB +: 16];
          end
        end
        ADDR_IRQ_STAT: next_irq_stat = irq_stat & ~pwdata[IRQ_N-1:0];
        ADDR_IRQ_MASK: next_irq_mask = pwdata[IRQ_N-1:0];
        default: next_irq_mask = irq_mask;
      endcase
    end
    // New events win over a clear in the same cycle.
    next_irq_stat = next_irq_stat | events;
    next_prdata = prdata;
    if (psel & ~penable)
    begin
      next_prdata = 32'h0;
      unique case (paddr)
        ADDR_CTRL: next_prdata[1:0] = ctrl;
        ADDR_PARAM: next_prdata = {pattern, 8'h00, PARAM_SLOT, 2'b00, fs_code};
        ADDR_STATUS: next_prdata = status_word;
        ADDR_IN: next_prdata[7:0] = in_image;
        ADDR_OUT: next_prdata[11:0] = {conn_shared, ready, failsafe, 1'b0, device_output};
        ADDR_DIAG: next_prdata[DIAG_N-1:0] = diag;
        ADDR_IRQ_STAT: next_prdata[IRQ_N-1:0] = irq_stat;
        ADDR_IRQ_MASK: next_prdata[IRQ_N-1:0] = irq_mask;
        default: next_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= CTRL_RESET;
      fs_code <= FS_CLEAR;
      pattern <= PATTERN_RESET;
      irq_stat <= '0;
      irq_mask <= '0;
      prdata <= 32'h0;
    end
    else
    begin
      ctrl <= next_ctrl;
      fs_code <= next_fs_code;
      pattern <= next_pattern;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      prdata <= next_prdata;
    end
  end

  property p_fault_lamp;
    @(posedge pclk) disable iff (!presetn)
    presetn |=> station_fault_indicator == $past(overtemp | sensor_supply_surge |
      sensor_supply_overload | actuator_supply_surge | actuator_supply_undervolt | (|out_short));
  endproperty
  a_fault_lamp: assert property (p_fault_lamp) else $error("fault lamp mismatch");

  property p_incoming;
    @(posedge pclk) disable iff (!presetn)
    $rose(diag[0]) |-> alarm_incoming[0] && !alarm_outgoing[0];
  endproperty
  a_incoming: assert property (p_incoming) else $error("no incoming alarm");

  property p_outgoing;
    @(posedge pclk) disable iff (!presetn)
    $fell(diag[DIAG_N-1]) |-> alarm_outgoing[DIAG_N-1];
  endproperty
  a_outgoing: assert property (p_outgoing) else $error("no outgoing alarm");

  property p_group;
    @(posedge pclk) disable iff (!presetn)
    (out_short[3:0] != 4'h0) |=> diag[5];
  endproperty
  a_group: assert property (p_group) else $error("short group not stored");

  property p_fs_clear;
    @(posedge pclk) disable iff (!presetn)
    failsafe && fs_code == FS_CLEAR |=> device_output == 8'h00;
  endproperty
  a_fs_clear: assert property (p_fs_clear) else $error("clear failsafe wrong");

  property p_fs_set;
    @(posedge pclk) disable iff (!presetn)
    failsafe && fs_code == FS_SET |=> device_output == 8'hff;
  endproperty
  a_fs_set: assert property (p_fs_set) else $error("set failsafe wrong");

  property p_fs_pattern;
    @(posedge pclk) disable iff (!presetn)
    failsafe && fs_code == FS_PATTERN |=> device_output == $past(pattern[7:0]);
  endproperty
  a_fs_pattern: assert property (p_fs_pattern) else $error("pattern wrong");

  property p_owner_only;
    @(posedge pclk) disable iff (!presetn)
    cyc_wr && cyc_src |=> out_data == $past(out_data);
  endproperty
  a_owner_only: assert property (p_owner_only) else $error("second controller wrote");

  property p_live_out;
    @(posedge pclk) disable iff (!presetn)
    !failsafe && owner_wr |=> device_output == $past(cyc_data);
  endproperty
  a_live_out: assert property (p_live_out) else $error("output map wrong");

  property p_in_map;
    @(posedge pclk) disable iff (!presetn)
    presetn |=> in_image == $past(device_input);
  endproperty
  a_in_map: assert property (p_in_map) else $error("input map wrong");

  property p_slot_gate;
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ADDR_PARAM && pwdata[7:4] != PARAM_SLOT |=> $stable(fs_code);
  endproperty
  a_slot_gate: assert property (p_slot_gate) else $error("param from wrong slot");

  property p_not_early;
    @(posedge pclk) disable iff (!presetn)
    ready |-> $past(cnt) >= (ctrl[CTRL_FAST_BIT] ? fast_cycles : boot_cycles) || $past(ready);
  endproperty
  a_not_early: assert property (p_not_early) else $error("ready too early");

  property p_status_top;
    @(posedge pclk) disable iff (!presetn)
    status_word[31:6] == 26'h0;
  endproperty
  a_status_top: assert property (p_status_top) else $error("reserved status set");

  property p_im;
    @(posedge pclk) disable iff (!presetn)
    im_req && im_slot != IM_SLOT |=> im_nak && !im_ack;
  endproperty
  a_im: assert property (p_im) else $error("wrong slot answered");

  c_failsafe_pattern: cover property (@(posedge pclk) disable iff (!presetn)
    failsafe && fs_code == FS_PATTERN ##1 device_output != 8'h00);
  c_alarm_pair: cover property (@(posedge pclk) disable iff (!presetn)
    alarm_incoming[0] ##[1:20] alarm_outgoing[0]);
  c_owner_write: cover property (@(posedge pclk) disable iff (!presetn)
    ready && owner_wr);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule // digital_io_process_image

// ===== dv/controller_model.sv
// Behavioural model of the two remote controllers feeding cyclic output data.
`timescale 1ns/1ns
module controller_model (
  input wire logic pclk,
  output logic cyc_wr,
  output logic cyc_src,
  output logic [7:0] cyc_data,
  output logic conn_owner,
  output logic conn_shared
);
  initial
  begin
    cyc_wr = 1'b0;
    cyc_src = 1'b0;
    cyc_data = 8'h00;
    conn_owner = 1'b0;
    conn_shared = 1'b0;
  end

  task automatic link(input logic own, input logic shr);
    @(posedge pclk);
    conn_owner <= own;
    conn_shared <= shr;
  endtask

  task automatic send(input logic src, input logic [7:0] d);
    @(posedge pclk);
    cyc_wr <= 1'b1;
    cyc_src <= src;
    cyc_data <= d;
    @(posedge pclk);
    cyc_wr <= 1'b0;
    // The idle data line shows junk so a stale byte is never mistaken for a write.
    cyc_data <= ~d;
  endtask
endmodule // controller_model

// ===== dv/testbench.sv
// Self-checking testbench for the digital I/O process image.
`timescale 1ns/1ns
module testbench;
  import dio_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, ready;
  logic [7:0] paddr, device_input, device_output, in_image, cyc_data;
  logic [31:0] pwdata, prdata, status_word, rd;
  logic [5:0] st;
  logic [6:0] dg, alarm_incoming, alarm_outgoing;
  logic cyc_wr, cyc_src, conn_owner, conn_shared, station_fault_indicator;
  logic im_req, im_ack, im_nak, replace_req, replace_ack, replace_nak;
  logic [3:0] im_slot;
  logic [2:0] im_index;
  int fails = 0;
  int comparisons = 0;
  int n, ni, no;
  logic [7:0] fs_exp [4] = '{8'h00, 8'hff, 8'ha5, 8'hc3};

  controller_model i_controller_model (.pclk(pclk), .cyc_wr(cyc_wr), .cyc_src(cyc_src),
    .cyc_data(cyc_data), .conn_owner(conn_owner), .conn_shared(conn_shared));

  digital_io_process_image #(.fast_cycles(CNT_W'(20)), .boot_cycles(CNT_W'(40)))
    i_digital_io_process_image (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .device_input(device_input),
    .device_output(device_output), .in_image(in_image), .status_word(status_word),
    .elec_undervolt(st[5]), .actuator_supply_overload(st[4]),
    .actuator_supply_undervolt(st[3] | dg[4]), .actuator_supply_surge(dg[3]),
    .sensor_supply_surge(dg[1]), .sensor_supply_overload(dg[2]),
    .sensor_supply_short(st[0]), .overtemp(dg[0]),
    .out_short({st[2], dg[6], 4'h0, dg[5], 1'b0}), .out_overload({st[1], 7'h0}),
    .conn_owner(conn_owner), .conn_shared(conn_shared), .cyc_wr(cyc_wr),
    .cyc_src(cyc_src), .cyc_data(cyc_data), .alarm_incoming(alarm_incoming),
    .alarm_outgoing(alarm_outgoing), .station_fault_indicator(station_fault_indicator),
    .ready(ready), .im_req(im_req), .im_slot(im_slot), .im_index(im_index),
    .im_ack(im_ack), .im_nak(im_nak), .replace_req(replace_req),
    .replace_ack(replace_ack), .replace_nak(replace_nak));

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic summarize;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      fails++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Counts single-entry alarm pulses over a short window, so latency need not be exact.
  task automatic count_alarms(input int k);
    ni = 0;
    no = 0;
    repeat (6)
    begin
      @(posedge pclk);
      #1;
      ni += (alarm_incoming === 7'(1 << k));
      no += (alarm_outgoing === 7'(1 << k));
    end
  endtask

  task automatic req(input logic kind, input logic [3:0] s, input logic [2:0] x,
                     input logic ok);
    @(posedge pclk);
    im_req <= !kind;
    replace_req <= kind;
    im_slot <= s;
    im_index <= x;
    @(posedge pclk);
    im_req <= 1'b0;
    replace_req <= 1'b0;
    #1;
    chk(kind ? {replace_ack, replace_nak} : {im_ack, im_nak}, {ok, !ok});
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    device_input = 8'h00;
    st = 6'h00;
    dg = 7'h00;
    im_req = 1'b0;
    replace_req = 1'b0;
    im_slot = 4'h0;
    im_index = 3'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wait_cyc(1);
    chk(device_output, 8'h00);
    n = 1;
    while (ready !== 1'b1 && n < 100)
    begin
      wait_cyc(1);
      n++;
    end
    chk(n >= 20 && n <= 24, 1'b1);
    if (ready !== 1'b1)
      summarize();
    rdchk(ADDR_CTRL, 32'h1);
    rdchk(ADDR_PARAM, 32'h20);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge pclk);
      device_input <= 8'h01 << i;
      wait_cyc(2);
      chk(in_image, 1 << i);
      rdchk(ADDR_IN, 1 << i);
    end
    for (int i = 0; i < 6; i++)
    begin
      @(posedge pclk);
      st <= 6'(1 << i);
      wait_cyc(2);
      chk(status_word, 1 << i);
      rdchk(ADDR_STATUS, 1 << i);
    end
    @(posedge pclk);
    st <= 6'h00;
    i_controller_model.link(1'b1, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      i_controller_model.send(1'b0, 8'h01 << i);
      wait_cyc(1);
      chk(device_output, 1 << i);
    end
    i_controller_model.send(1'b0, 8'ha5);
    i_controller_model.send(1'b1, 8'h3c);
    wait_cyc(2);
    chk(device_output, 8'ha5);
    rdchk(ADDR_OUT, 32'h00000ca5);
    for (int c = 0; c < 4; c++)
    begin
      i_controller_model.link(1'b1, 1'b1);
      i_controller_model.send(1'b0, 8'ha5);
      wr(ADDR_PARAM, {16'h12c3, 8'h00, PARAM_SLOT, 2'b00, 2'(c)});
      i_controller_model.link(1'b0, 1'b1);
      wait_cyc(3);
      chk(device_output, fs_exp[c]);
    end
    i_controller_model.link(1'b1, 1'b1);
    wr(ADDR_PARAM, {16'h0000, 8'h00, 4'h3, 4'h1});
    rdchk(ADDR_PARAM, {16'h12c3, 8'h00, PARAM_SLOT, 4'h3});
    // Ready, failsafe entries and the status-loop faults have all left events behind.
    rdchk(ADDR_IRQ_STAT, 32'hf);
    wr(ADDR_IRQ_STAT, 32'hf);
    wr(ADDR_IRQ_MASK, 32'h1);
    chk(irq, 1'b0);
    for (int k = 0; k < 7; k++)
    begin
      @(posedge pclk);
      dg <= 7'(1 << k);
      count_alarms(k);
      chk(ni, 1);
      chk(station_fault_indicator, 1'b1);
      rdchk(ADDR_DIAG, 1 << k);
      @(posedge pclk);
      dg <= 7'h00;
      count_alarms(k);
      chk(no, 1);
      chk(station_fault_indicator, 1'b0);
    end
    chk(irq, 1'b1);
    rdchk(ADDR_IRQ_STAT, 32'h3);
    wr(ADDR_IRQ_STAT, 32'h1);
    chk(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h2);
    chk(irq, 1'b1);
    for (int x = 0; x < 8; x++)
      req(1'b0, IM_SLOT, 3'(x), x <= 4);
    req(1'b0, 4'h2, 3'h0, 1'b0);
    req(1'b1, 4'h0, 3'h0, 1'b1);
    wr(ADDR_CTRL, 32'h3);
    req(1'b1, 4'h0, 3'h0, 1'b0);
    // A second reset in mid-run, with fast startup switched off while booting.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wr(ADDR_CTRL, 32'h0);
    chk(device_output, 8'h00);
    rdchk(ADDR_OUT, 32'h00000a00);
    n = 6;
    while (ready !== 1'b1 && n < 100)
    begin
      wait_cyc(1);
      n++;
    end
    chk(n >= 40 && n <= 44, 1'b1);
    if (ready !== 1'b1)
      summarize();
    rdchk(ADDR_OUT, 32'h00000c00);
    summarize();
  end
endmodule // testbench
